// >>> dv/fifo_reset_port_config_tb.sv
// Self-checking bench: host end and device end joined over the link
`timescale 1ns/1ps
module fifo_reset_port_config_tb;
  logic mclk;
  logic reset;
  logic [3:0] modeRequest;
  logic softResetRequest;
  logic writeRequest;
  logic [frc_pkg::DATA_W-1:0] writeWord;
  logic readRequest;
  logic busy;
  logic ready;
  logic [frc_pkg::CFG_W-1:0] activeConfig;
  logic [frc_pkg::PTR_W:0] wordCount;
  int num_errors;
  int n_compared;
  frc_link_if link();
  frc_fifo_device u_frc_fifo_device (.mclk(mclk), .reset(reset), .link(link),
    .activeConfig(activeConfig), .wordCount(wordCount));
  frc_fifo_host u_frc_fifo_host (.mclk(mclk), .reset(reset), .link(link),
    .modeRequest(modeRequest), .softResetRequest(softResetRequest),
    .writeRequest(writeRequest), .writeWord(writeWord), .readRequest(readRequest),
    .busy(busy), .ready(ready));
  frc_link_assertions u_frc_link_assertions (.mclk(mclk), .reset(reset),
    .fullResetN(link.fullResetN), .softResetN(link.softResetN),
    .fallThroughSerialIn(link.fallThroughSerialIn),
    .writePortAsyncSelectN(link.writePortAsyncSelectN),
    .readPortAsyncSelectN(link.readPortAsyncSelectN), .writeEnN(link.writeEnN),
    .readEnN(link.readEnN), .readDataOut(link.readDataOut), .emptyFlagN(link.emptyFlagN),
    .fullFlagN(link.fullFlagN), .halfFullFlagN(link.halfFullFlagN),
    .progAlmostEmptyN(link.progAlmostEmptyN), .progAlmostFullN(link.progAlmostFullN));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic conclude();
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Host drops ready on a request; give it time, then poll with a bound
  task automatic waitReady(input int bound);
    int i;
    repeat (2) @(negedge mclk);
    i = 0;
    while (ready !== 1'b1 && i < bound) begin
      @(negedge mclk);
      i++;
    end
    if (ready !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED ready expected 1 seen %b", ready);
      conclude();
    end else begin
      // Device pin filter and flag register lag the host
      repeat (6) @(negedge mclk);
    end
  endtask
  task automatic fullReset(input logic [3:0] mode);
    @(negedge mclk);
    modeRequest = mode;
    reset = 1'b1;
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    waitReady(400);
  endtask
  task automatic pulse(input int which, input logic [frc_pkg::DATA_W-1:0] word);
    @(negedge mclk);
    writeWord = word;
    writeRequest = (which == 0);
    readRequest = (which == 1);
    softResetRequest = (which == 2);
    @(negedge mclk);
    writeRequest = 1'b0;
    readRequest = 1'b0;
    softResetRequest = 1'b0;
    waitReady(200);
  endtask
  task automatic chkFlags(input logic [4:0] exp);
    chk("flags", {27'h0, exp}, {27'h0, link.emptyFlagN, link.fullFlagN,
      link.halfFullFlagN, link.progAlmostEmptyN, link.progAlmostFullN});
  endtask
  task automatic chkCfg(input logic ft, input logic wa, input logic ra, input logic iw);
    chk("config", {28'h0, ft, wa, ra, iw}, {28'h0, activeConfig[frc_pkg::CFG_FT],
      activeConfig[frc_pkg::CFG_WASYNC_N], activeConfig[frc_pkg::CFG_RASYNC_N],
      activeConfig[frc_pkg::CFG_IW]});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    num_errors = 0;
    n_compared = 0;
    reset = 1'b1;
    modeRequest = 4'h0;
    softResetRequest = 1'b0;
    writeRequest = 1'b0;
    writeWord = 18'h00000;
    readRequest = 1'b0;
    // Synchronous ports, standard mode, wide input
    fullReset(4'h0);
    chkFlags(5'b01101);
    chk("data", 32'h0, {14'h0, link.readDataOut});
    chk("count", 32'h0, {27'h0, wordCount});
    chkCfg(1'b0, 1'b1, 1'b1, 1'b1);
    chk("oe", 32'h1, {31'h0, link.readDataOe});
    chk("busy", 32'h0, {31'h0, busy});
    pulse(0, 18'h2a5a5);
    pulse(0, 18'h15a5a);
    chk("count", 32'h2, {27'h0, wordCount});
    chk("empty", 32'h1, {31'h0, link.emptyFlagN});
    pulse(1, 18'h00000);
    chk("data", 32'h2a5a5, {14'h0, link.readDataOut});
    // Both ports strobed, narrow input
    fullReset(4'he);
    chkCfg(1'b0, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < frc_pkg::DEPTH + 1; k++) begin
      pulse(0, 18'h3ff00 + 18'(k));
    end
    chk("count", frc_pkg::DEPTH, {27'h0, wordCount});
    chk("full", 32'h0, {31'h0, link.fullFlagN});
    pulse(1, 18'h00000);
    chk("data", 32'h100, {14'h0, link.readDataOut});
    chk("full", 32'h1, {31'h0, link.fullFlagN});
    chk("half", 32'h0, {31'h0, link.halfFullFlagN});
    pulse(2, 18'h00000);
    chk("count", 32'h0, {27'h0, wordCount});
    chkFlags(5'b01101);
    chk("data", 32'h0, {14'h0, link.readDataOut});
    chkCfg(1'b0, 1'b0, 1'b0, 1'b0);
    pulse(0, 18'h00abc);
    chk("empty", 32'h1, {31'h0, link.emptyFlagN});
    // Fall-through with synchronous ports
    fullReset(4'h1);
    chkCfg(1'b1, 1'b1, 1'b1, 1'b1);
    chkFlags(5'b10101);
    pulse(2, 18'h00000);
    chkFlags(5'b10101);
    chkCfg(1'b1, 1'b1, 1'b1, 1'b1);
    // First word falls through on the third read edge, no enable needed
    pulse(0, 18'h1c3c3);
    pulse(1, 18'h00000);
    pulse(1, 18'h00000);
    chk("data", 32'h0, {14'h0, link.readDataOut});
    chk("ready", 32'h1, {31'h0, link.emptyFlagN});
    pulse(1, 18'h00000);
    chk("data", 32'h1c3c3, {14'h0, link.readDataOut});
    chkFlags(5'b00101);
    chk("count", 32'h0, {27'h0, wordCount});
    // Fall-through asked together with a strobed write port
    fullReset(4'h3);
    chkCfg(1'b0, 1'b0, 1'b1, 1'b1);
    chkFlags(5'b01101);
    conclude();
  end
endmodule

// >>> dv/frc_link_assertions.sv
// Concurrent checks on the link between the FIFO device end and the host end
`timescale 1ns/1ps
module frc_link_assertions (
  input wire logic mclk,
  input wire logic reset,
  input wire logic fullResetN,
  input wire logic softResetN,
  input wire logic fallThroughSerialIn,
  input wire logic writePortAsyncSelectN,
  input wire logic readPortAsyncSelectN,
  input wire logic writeEnN,
  input wire logic readEnN,
  input wire logic [frc_pkg::DATA_W-1:0] readDataOut,
  input wire logic emptyFlagN,
  input wire logic fullFlagN,
  input wire logic halfFullFlagN,
  input wire logic progAlmostEmptyN,
  input wire logic progAlmostFullN
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  // Seven low samples clear the device's pin filter plus the flag register
  a_full_reset_flags: assert property (!fullResetN[*7] |-> halfFullFlagN &&
    !progAlmostEmptyN && progAlmostFullN) else $error("full reset flags wrong");
  a_std_mode_flags: assert property ((!fullResetN && !fallThroughSerialIn)[*7] |->
    !emptyFlagN && fullFlagN) else $error("standard mode reset flags wrong");
  a_ft_mode_flags: assert property ((!fullResetN && fallThroughSerialIn)[*7] |->
    emptyFlagN && !fullFlagN) else $error("fall-through reset flags wrong");
  a_full_reset_zero: assert property (!fullResetN[*7] |->
    readDataOut == frc_pkg::OUT_RESET) else $error("output not cleared by full reset");
  // Host holds soft reset four cycles; the pin filter and flag register add two
  a_soft_reset_state: assert property (!softResetN[*4] |-> ##2 (halfFullFlagN &&
    !progAlmostEmptyN && progAlmostFullN && readDataOut == frc_pkg::OUT_RESET))
    else $error("soft reset state wrong");
  a_async_write_en: assert property (fullResetN && !writePortAsyncSelectN |->
    !writeEnN) else $error("write enable not held low in strobe mode");
  a_async_read_en: assert property (fullResetN && !readPortAsyncSelectN |->
    !readEnN) else $error("read enable not held low in strobe mode");
  a_no_ft_async: assert property (!fullResetN &&
    (!writePortAsyncSelectN || !readPortAsyncSelectN) |-> !fallThroughSerialIn)
    else $error("fall-through chosen with a strobe port");
endmodule

// >>> logic/frc_fifo_device.sv
// FIFO device end: reset, mode capture, strobe ports and status flags
//
// Notes on behaviour
// - Full reset returns both pointers to start.
// - Full reset: almost-empty low, almost-full, half high.
// - Serial-in low at reset: standard mode flags.
// - Serial-in high at reset: fall-through ready flags.
// - Static settings captured only during full reset.
// - Full reset zeroes the output register.
// - Host applies full reset before any write.
// - Soft reset: pointers home, same programmable flags.
// - Soft reset keeps mode, sets its idle flags.
// - Soft reset keeps offsets and programming method.
// - Soft reset zeroes the output register.
// - Async write: strobe rising edge stores data.
// - Async write: host holds write enable low.
// - Async write: full flag follows both ports.
// - Host avoids fall-through with async write.
// - Async read: strobe rising edge reads data.
// - Async read: host holds read enable low.
// - Drive enable or port select controls bus.
// - Async read: empty flag follows both ports.
// - Host picks standard mode with async read.
// - Input eighteen bits wide, or nine low.
// - Fall-through first word shows after three edges.
`timescale 1ns/1ps
module frc_fifo_device #(
  parameter int DataW = frc_pkg::DATA_W,
  parameter int Depth = frc_pkg::DEPTH,
  parameter int AlmostOffset = frc_pkg::ALMOST_OFFSET
) (
  input wire logic mclk,
  input wire logic reset,
  frc_link_if.device link,
  output logic [frc_pkg::CFG_W-1:0] activeConfig,
  output logic [frc_pkg::PTR_W:0] wordCount
);
  initial begin
    if (DataW != frc_pkg::DATA_W || Depth != (1 << frc_pkg::PTR_W) || AlmostOffset < 1
        || AlmostOffset >= Depth / 2) begin
      $error("frc_fifo_device: unsupported parameters");
    end
  end

  localparam int PW = frc_pkg::PTR_W;
  localparam logic [PW:0] DEPTH_CNT = (PW + 1)'(Depth);
  localparam logic [PW:0] HALF_CNT = (PW + 1)'(Depth / 2);
  localparam logic [PW:0] AE_CNT = (PW + 1)'(AlmostOffset);
  localparam logic [PW:0] AF_CNT = (PW + 1)'(Depth - AlmostOffset);
  localparam logic [1:0] FT_EDGES = 2'(frc_pkg::FALL_THROUGH_EDGES);

  // Pin inputs cross from the host's domain: three stages, second and third agree
  logic [8:0] pinS1_r, pinS2_r, pinS3_r, pin_r;
  logic [8:0] pinRaw;
  assign pinRaw = {link.fullResetN, link.softResetN, link.writeStrobe, link.writeEnN,
    link.readStrobe, link.readEnN, link.readPortSelectN, link.outputDriveEnN,
    link.fallThroughSerialIn};
  always_ff @(posedge mclk) begin
    if (reset) begin
      pinS1_r <= 9'h1ff;
      pinS2_r <= 9'h1ff;
      pinS3_r <= 9'h1ff;
      pin_r <= 9'h1ff;
    end else begin
      pinS1_r <= pinRaw;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
      for (int i = 0; i < 9; i++) begin
        if (pinS2_r[i] == pinS3_r[i]) begin
          pin_r[i] <= pinS3_r[i];
        end
      end
    end
  end
  logic fullRstN, softRstN, wStrobe, wEnN, rStrobe, rEnN, rSelN, oeN, ftIn;
  assign {fullRstN, softRstN, wStrobe, wEnN, rStrobe, rEnN, rSelN, oeN, ftIn} = pin_r;

  // Data is only sampled on a settled strobe edge, long after it has stopped moving
  logic [DataW-1:0] dataS1_r, dataS2_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      dataS1_r <= '0;
      dataS2_r <= '0;
    end else begin
      dataS1_r <= link.writeDataIn;
      dataS2_r <= dataS1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode capture
  logic [frc_pkg::CFG_W-1:0] cfg_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_r <= frc_pkg::CFG_RESET;
    end else if (!fullRstN) begin
      cfg_r <= {link.parityPlacementSelect, link.flagTimingMode, link.byteOrderSelect,
        link.inputWidthSelect, link.outputWidthSelect, link.readPortAsyncSelectN,
        link.writePortAsyncSelectN, ftIn};
    end
  end
  logic ftMode, wAsync, rAsync, narrowIn;
  assign ftMode = cfg_r[frc_pkg::CFG_FT];
  assign wAsync = !cfg_r[frc_pkg::CFG_WASYNC_N];
  assign rAsync = !cfg_r[frc_pkg::CFG_RASYNC_N];
  assign narrowIn = !cfg_r[frc_pkg::CFG_IW];

  ////////////////////////////////////////////////////////////////////////////////
  // Port events
  logic wStrobePrev_r, rStrobePrev_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      wStrobePrev_r <= 1'b1;
      rStrobePrev_r <= 1'b1;
    end else begin
      wStrobePrev_r <= wStrobe;
      rStrobePrev_r <= rStrobe;
    end
  end
  logic anyRst, wEdge, rEdge, doWrite, doRead, ftLoad;
  logic [PW:0] count_r;
  logic outValid_r;
  logic [1:0] ftWait_r;
  assign anyRst = !fullRstN || !softRstN;
  assign wEdge = wStrobe && !wStrobePrev_r;
  assign rEdge = rStrobe && !rStrobePrev_r;
  // Async strobe ports ignore the enable pins; the host ties them low
  assign doWrite = !anyRst && wEdge && (wAsync || !wEnN) && count_r != DEPTH_CNT;
  assign ftLoad = ftMode && !outValid_r && ftWait_r == FT_EDGES - 2'h1 && rEdge
    && count_r != '0;
  assign doRead = !anyRst && rEdge && count_r != '0 && (ftMode ? (ftLoad ||
    (outValid_r && !rEnN)) : (rAsync || !rEnN));

  logic [DataW-1:0] mem [Depth];
  logic [PW-1:0] wPtr_r, rPtr_r;
  logic [DataW-1:0] wWord;
  assign wWord = narrowIn ? {{(DataW - frc_pkg::NARROW_W){1'b0}},
    dataS2_r[frc_pkg::NARROW_W-1:0]} : dataS2_r;
  always_ff @(posedge mclk) begin
    if (doWrite) begin
      mem[wPtr_r] <= wWord;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset || anyRst) begin
      wPtr_r <= frc_pkg::FIRST_LOC;
      rPtr_r <= frc_pkg::FIRST_LOC;
    end else begin
      if (doWrite) begin
        wPtr_r <= wPtr_r + 1'b1;
      end
      if (doRead) begin
        rPtr_r <= rPtr_r + 1'b1;
      end
    end
  end
  // Count tracks both ports at once, so full and empty answer either side
  always_ff @(posedge mclk) begin
    if (reset || anyRst) begin
      count_r <= '0;
    end else if (doWrite && !doRead) begin
      count_r <= count_r + 1'b1;
    end else if (doRead && !doWrite) begin
      count_r <= count_r - 1'b1;
    end
  end
  // Fall-through waits three read edges with data present
  always_ff @(posedge mclk) begin
    if (reset || anyRst || outValid_r || count_r == '0) begin
      ftWait_r <= '0;
    end else if (ftMode && rEdge && ftWait_r != FT_EDGES - 2'h1) begin
      ftWait_r <= ftWait_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output register and flags
  logic [DataW-1:0] readData_r;
  always_ff @(posedge mclk) begin
    if (reset || anyRst) begin
      readData_r <= frc_pkg::OUT_RESET;
      outValid_r <= 1'b0;
    end else if (doRead) begin
      readData_r <= mem[rPtr_r];
      outValid_r <= 1'b1;
    end else if (ftMode && !rEnN && rEdge && count_r == '0) begin
      outValid_r <= 1'b0;
    end
  end
  logic readOe_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      readOe_r <= 1'b0;
    end else begin
      readOe_r <= rAsync ? !oeN : !rSelN;
    end
  end
  logic emptyN_r, fullN_r, halfN_r, almostEmptyN_r, almostFullN_r;
  always_ff @(posedge mclk) begin
    if (reset || anyRst) begin
      almostEmptyN_r <= 1'b0;
      almostFullN_r <= 1'b1;
      halfN_r <= 1'b1;
      // Soft reset reuses the held mode; offsets live in constants here
      emptyN_r <= ftMode ? 1'b1 : 1'b0;
      fullN_r <= ftMode ? 1'b0 : 1'b1;
    end else begin
      almostEmptyN_r <= count_r > AE_CNT;
      almostFullN_r <= count_r < AF_CNT;
      halfN_r <= count_r <= HALF_CNT;
      emptyN_r <= ftMode ? !outValid_r : count_r != '0;
      fullN_r <= ftMode ? count_r == DEPTH_CNT : count_r != DEPTH_CNT;
    end
  end
  assign link.readDataOut = readData_r;
  assign link.readDataOe = readOe_r;
  assign link.emptyFlagN = emptyN_r;
  assign link.fullFlagN = fullN_r;
  assign link.halfFullFlagN = halfN_r;
  assign link.progAlmostEmptyN = almostEmptyN_r;
  assign link.progAlmostFullN = almostFullN_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      wordCount <= '0;
    end else begin
      wordCount <= count_r;
    end
  end
  assign activeConfig = cfg_r;
endmodule

// >>> logic/frc_fifo_host.sv
// Host end: applies full reset, sets modes and drives the strobe ports
`timescale 1ns/1ps
module frc_fifo_host #(
  parameter int DataW = frc_pkg::DATA_W,
  parameter int ResetCycles = 8,
  parameter int StrobeHalf = 4
) (
  input wire logic mclk,
  input wire logic reset,
  frc_link_if.host link,
  input wire logic [3:0] modeRequest,
  input wire logic softResetRequest,
  input wire logic writeRequest,
  input wire logic [DataW-1:0] writeWord,
  input wire logic readRequest,
  output logic busy,
  output logic ready
);
  initial begin
    if (ResetCycles < 8 || StrobeHalf < 4 || DataW != frc_pkg::DATA_W) begin
      $error("frc_fifo_host: unsupported parameters");
    end
  end
  frc_pkg::frc_host_state_t state_r;
  logic [7:0] cnt_r;
  logic [3:0] mode_r;
  logic fullRstN_r, softRstN_r, wStb_r, rStb_r;
  logic [1:0] op_r;
  logic [DataW-1:0] data_r;
  // Mode bits: 0 fall-through, 1 write async, 2 read async, 3 narrow input
  logic wantFt;
  assign wantFt = modeRequest[0] && !modeRequest[1] && !modeRequest[2];

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= frc_pkg::FRC_HOST_RESET;
      cnt_r <= '0;
      mode_r <= 4'h0;
      fullRstN_r <= 1'b0;
      softRstN_r <= 1'b1;
      wStb_r <= 1'b1;
      rStb_r <= 1'b1;
      op_r <= 2'h0;
      data_r <= '0;
    end else begin
      unique case (state_r)
        frc_pkg::FRC_HOST_RESET: begin
          mode_r <= {modeRequest[3:1], wantFt};
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(ResetCycles - 1)) begin
            fullRstN_r <= 1'b1;
            cnt_r <= '0;
            state_r <= frc_pkg::FRC_HOST_RELEASE;
          end
        end
        frc_pkg::FRC_HOST_RELEASE: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(ResetCycles - 1)) begin
            cnt_r <= '0;
            state_r <= frc_pkg::FRC_HOST_RUN;
          end
        end
        frc_pkg::FRC_HOST_RUN: begin
          if (op_r != 2'h0) begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == 8'(StrobeHalf - 1)) begin
              wStb_r <= op_r[0] ? 1'b1 : wStb_r;
              rStb_r <= op_r[1] ? 1'b1 : rStb_r;
              softRstN_r <= 1'b1;
            end
            if (cnt_r == 8'(2 * StrobeHalf - 1)) begin
              cnt_r <= '0;
              op_r <= 2'h0;
            end
          end else if (softResetRequest) begin
            // Strobes stay high: a rise as soft reset ends would store a word
            softRstN_r <= 1'b0;
            op_r <= 2'h3;
          end else if (writeRequest || readRequest) begin
            op_r <= {readRequest, writeRequest};
            data_r <= writeWord;
            wStb_r <= writeRequest ? 1'b0 : wStb_r;
            rStb_r <= readRequest ? 1'b0 : rStb_r;
          end
        end
        default: begin
          state_r <= frc_pkg::FRC_HOST_RESET;
        end
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      busy <= 1'b1;
      ready <= 1'b0;
    end else begin
      busy <= state_r != frc_pkg::FRC_HOST_RUN || op_r != 2'h0;
      ready <= state_r == frc_pkg::FRC_HOST_RUN && op_r == 2'h0;
    end
  end
  assign link.fullResetN = fullRstN_r;
  assign link.softResetN = softRstN_r;
  assign link.fallThroughSerialIn = mode_r[0];
  assign link.writePortAsyncSelectN = !mode_r[1];
  assign link.readPortAsyncSelectN = !mode_r[2];
  assign link.outputWidthSelect = 1'b1;
  assign link.inputWidthSelect = !mode_r[3];
  assign link.byteOrderSelect = 1'b0;
  assign link.flagTimingMode = 1'b0;
  assign link.parityPlacementSelect = 1'b0;
  assign link.writeStrobe = wStb_r;
  assign link.writeEnN = 1'b0;
  assign link.writeDataIn = data_r;
  assign link.readStrobe = rStb_r;
  assign link.readEnN = 1'b0;
  assign link.readPortSelectN = 1'b0;
  assign link.outputDriveEnN = 1'b0;
endmodule

// >>> logic/frc_link_if.sv
// Pin-level link between the FIFO device end and its controlling host end
`timescale 1ns/1ps
interface frc_link_if;
  logic fullResetN;
  logic softResetN;
  logic fallThroughSerialIn;
  logic writePortAsyncSelectN;
  logic readPortAsyncSelectN;
  logic outputWidthSelect;
  logic inputWidthSelect;
  logic byteOrderSelect;
  logic flagTimingMode;
  logic parityPlacementSelect;
  logic writeStrobe;
  logic writeEnN;
  logic [frc_pkg::DATA_W-1:0] writeDataIn;
  logic readStrobe;
  logic readEnN;
  logic readPortSelectN;
  logic outputDriveEnN;
  logic [frc_pkg::DATA_W-1:0] readDataOut;
  logic readDataOe;
  logic emptyFlagN;
  logic fullFlagN;
  logic halfFullFlagN;
  logic progAlmostEmptyN;
  logic progAlmostFullN;
  modport device (
    input fullResetN, softResetN, fallThroughSerialIn, writePortAsyncSelectN,
    input readPortAsyncSelectN, outputWidthSelect, inputWidthSelect, byteOrderSelect,
    input flagTimingMode, parityPlacementSelect, writeStrobe, writeEnN, writeDataIn,
    input readStrobe, readEnN, readPortSelectN, outputDriveEnN,
    output readDataOut, readDataOe, emptyFlagN, fullFlagN, halfFullFlagN,
    output progAlmostEmptyN, progAlmostFullN
  );
  modport host (
    output fullResetN, softResetN, fallThroughSerialIn, writePortAsyncSelectN,
    output readPortAsyncSelectN, outputWidthSelect, inputWidthSelect, byteOrderSelect,
    output flagTimingMode, parityPlacementSelect, writeStrobe, writeEnN, writeDataIn,
    output readStrobe, readEnN, readPortSelectN, outputDriveEnN,
    input readDataOut, readDataOe, emptyFlagN, fullFlagN, halfFullFlagN,
    input progAlmostEmptyN, progAlmostFullN
  );
endinterface

// >>> logic/frc_pkg.sv
// Shared constants and types for the FIFO reset and port-mode configuration pair
package frc_pkg;
  localparam int DATA_W = 18;
  localparam int NARROW_W = 9;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int FALL_THROUGH_EDGES = 3;
  localparam logic [PTR_W-1:0] FIRST_LOC = 4'h0;
  localparam logic [DATA_W-1:0] OUT_RESET = 18'h00000;
  localparam int ALMOST_OFFSET = 2;
  // Static settings captured while full reset is low
  localparam int CFG_W = 8;
  localparam int CFG_FT = 0;
  localparam int CFG_WASYNC_N = 1;
  localparam int CFG_RASYNC_N = 2;
  localparam int CFG_OW = 3;
  localparam int CFG_IW = 4;
  localparam int CFG_BE = 5;
  localparam int CFG_PFM = 6;
  localparam int CFG_IP = 7;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h06;
  typedef enum logic [1:0] {
    FRC_HOST_RESET = 2'b00,
    FRC_HOST_RELEASE = 2'b01,
    FRC_HOST_RUN = 2'b11
  } frc_host_state_t;
endpackage
